// ### src/bstp_consts.svh
// Opcodes, reset values and fixed codes of the boundary scan test port
`ifndef BSTP_CONSTS_SVH
`define BSTP_CONSTS_SVH

`define BSTP_IR_W 5
`define BSTP_OP_EXTEST 5'h00
`define BSTP_OP_SAMPLE 5'h01
`define BSTP_OP_IDCODE 5'h02
`define BSTP_OP_READBACK 5'h03
`define BSTP_OP_FLOAT 5'h08
`define BSTP_OP_PROGRAM 5'h10
`define BSTP_OP_RECONFIG 5'h11
`define BSTP_OP_USER_SIG 5'h16
`define BSTP_OP_BYPASS 5'h1f
`define BSTP_IR_RST `BSTP_OP_IDCODE
`define BSTP_IR_CAPT 5'h01
// Arbitrary identification value, names no real part
`define BSTP_ID_CODE 32'h0b57_0001
`define BSTP_USIG_DEF 32'h0000_0000
`define BSTP_DR_W 32
`define BSTP_SEC_WAIT 2'h2

`endif

// ### src/bstp_fifo.sv
// Single-clock FIFO for configuration words
`timescale 1ns/10ps
module bstp_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_ff [DEPTH];
  logic [W-1:0] nxt_mem [DEPTH];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic push, pop;

  // ==========================================================
  // Next state
  always_comb begin
    in_ready = (cnt_ff != (AW+1)'(DEPTH));
    out_valid = (cnt_ff != '0);
    out_data = mem_ff[rd_ff];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    nxt_mem = mem_ff;
    nxt_wr = wr_ff;
    nxt_rd = rd_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_mem[wr_ff] = in_data;
      nxt_wr = (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
    end
    if (pop) begin
      nxt_rd = (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
    end
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk) begin
    mem_ff <= nxt_mem;
    if (!rst_n) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end
endmodule

// ### src/bstp_pkg.sv
// Types shared by the boundary scan test port
package bstp_pkg;
  typedef enum logic [3:0] {
    TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
    SH_DR = 4'h4, EX1_DR = 4'h5, PAU_DR = 4'h6, EX2_DR = 4'h7,
    UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'ha, SH_IR = 4'hb,
    EX1_IR = 4'hc, PAU_IR = 4'hd, EX2_IR = 4'he, UPD_IR = 4'hf
  } bstp_tap_t;
endpackage

// ### src/bstp_top.sv
// Boundary scan test port with configuration download path
// What this block does
// - All pin cells form one serial chain
// - External test drives pins from cells
// - Bypass puts one bit between TDI, TDO
// - Sample snapshots pins without disturbing them
// - Preloaded cells drive pins under external test
// - Identification register shifts out on TDO
// - User signature register shifts out on TDO
// - Float opcode releases every pin
// - Program, verify and private opcodes accepted
// - Same four wires carry all programming
// - Reconfiguration downloads repeat without limit
// - Non-volatile writes need programming voltage
// - Security bit blocks configuration readback only
// - Security latched only in the two system clock cycles after each reset
// - Port has TMS, TDI, TCK in, TDO out
`timescale 1ns/10ps
`include "bstp_consts.svh"
module bstp_top import bstp_pkg::*; #(
  parameter int N_PINS = 8,
  parameter int CFG_W = 8,
  parameter int FIFO_DEPTH = 32,
  parameter logic [31:0] USIG_VALUE = `BSTP_USIG_DEF
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  output logic TDO,
  output logic TDO_OE,
  input wire logic [N_PINS-1:0] PIN_IN,
  input wire logic [N_PINS-1:0] CORE_OUT,
  input wire logic [N_PINS-1:0] CORE_OE,
  output logic [N_PINS-1:0] PIN_OUT,
  output logic [N_PINS-1:0] PIN_OE,
  output logic [N_PINS-1:0] CORE_IN,
  input wire logic SEC_BIT_NV,
  input wire logic VPP_OK,
  input wire logic [CFG_W-1:0] RB_DATA,
  output logic [CFG_W-1:0] CFG_DATA,
  output logic CFG_NV,
  output logic CFG_VALID,
  input wire logic CFG_READY,
  output logic SEC_LOCKED
);
  localparam int DW = `BSTP_DR_W;

  // ==========================================================
  // Test clock side
  bstp_tap_t tap_ff, nxt_tap;
  logic [4:0] ir_ff, nxt_ir, irsh_ff, nxt_irsh;
  logic [DW-1:0] dr_ff, nxt_dr, dr_cap;
  logic [N_PINS-1:0] bsc_ff, nxt_bsc, pin_t1, pin_t2;
  logic [CFG_W-1:0] rb_t1, rb_t2, hold_ff, nxt_hold;
  logic rst_t1, rst_t2, lck_t1, lck_t2, vpp_t1, vpp_t2, ack_t1, ack_t2;
  logic upd_tgl_ff, nxt_upd_tgl, cfg_tgl_ff, nxt_cfg_tgl;
  logic hold_nv_ff, nxt_hold_nv, ext_ff, nxt_ext, flt_ff, nxt_flt;
  logic tdo_ff, nxt_tdo, tdo_oe_ff, nxt_tdo_oe, cfg_ok, is_cfg;
  // System side flops read by the test clock synchronisers
  logic ack_ff, nxt_ack, locked_ff, nxt_locked;
  int dr_len;

  always_comb begin
    nxt_tap = tap_ff;
    case (tap_ff)
      TLR: nxt_tap = TMS ? TLR : RTI;
      RTI: nxt_tap = TMS ? SEL_DR : RTI;
      SEL_DR: nxt_tap = TMS ? SEL_IR : CAP_DR;
      CAP_DR: nxt_tap = TMS ? EX1_DR : SH_DR;
      SH_DR: nxt_tap = TMS ? EX1_DR : SH_DR;
      EX1_DR: nxt_tap = TMS ? UPD_DR : PAU_DR;
      PAU_DR: nxt_tap = TMS ? EX2_DR : PAU_DR;
      EX2_DR: nxt_tap = TMS ? UPD_DR : SH_DR;
      UPD_DR: nxt_tap = TMS ? SEL_DR : RTI;
      SEL_IR: nxt_tap = TMS ? TLR : CAP_IR;
      CAP_IR: nxt_tap = TMS ? EX1_IR : SH_IR;
      SH_IR: nxt_tap = TMS ? EX1_IR : SH_IR;
      EX1_IR: nxt_tap = TMS ? UPD_IR : PAU_IR;
      PAU_IR: nxt_tap = TMS ? EX2_IR : PAU_IR;
      EX2_IR: nxt_tap = TMS ? UPD_IR : SH_IR;
      UPD_IR: nxt_tap = TMS ? SEL_DR : RTI;
      default: nxt_tap = TLR;
    endcase
    if (!rst_t2) begin
      nxt_tap = TLR;
    end
  end

  always_comb begin
    is_cfg = (ir_ff == `BSTP_OP_PROGRAM) || (ir_ff == `BSTP_OP_RECONFIG);
    cfg_ok = (cfg_tgl_ff == ack_t2)
      && ((ir_ff != `BSTP_OP_PROGRAM) || vpp_t2);
    case (ir_ff)
      `BSTP_OP_EXTEST, `BSTP_OP_SAMPLE: dr_len = N_PINS;
      `BSTP_OP_IDCODE, `BSTP_OP_USER_SIG: dr_len = 32;
      `BSTP_OP_PROGRAM, `BSTP_OP_RECONFIG: dr_len = CFG_W;
      `BSTP_OP_READBACK: dr_len = CFG_W;
      default: dr_len = 1;
    endcase
    dr_cap = '0;
    case (ir_ff)
      `BSTP_OP_EXTEST, `BSTP_OP_SAMPLE: dr_cap[N_PINS-1:0] = pin_t2;
      `BSTP_OP_IDCODE: dr_cap[31:0] = `BSTP_ID_CODE;
      `BSTP_OP_USER_SIG: dr_cap[31:0] = USIG_VALUE;
      `BSTP_OP_READBACK: dr_cap[CFG_W-1:0] = lck_t2 ? '0 : rb_t2;
      `BSTP_OP_PROGRAM, `BSTP_OP_RECONFIG: dr_cap[0] = cfg_ok;
      default: dr_cap = '0;
    endcase
  end

  always_comb begin
    nxt_ir = ir_ff;
    nxt_irsh = irsh_ff;
    nxt_dr = dr_ff;
    nxt_bsc = bsc_ff;
    nxt_upd_tgl = upd_tgl_ff;
    nxt_cfg_tgl = cfg_tgl_ff;
    nxt_hold = hold_ff;
    nxt_hold_nv = hold_nv_ff;
    case (tap_ff)
      TLR: nxt_ir = `BSTP_IR_RST;
      CAP_IR: nxt_irsh = `BSTP_IR_CAPT;
      SH_IR: nxt_irsh = {TDI, irsh_ff[4:1]};
      UPD_IR: nxt_ir = irsh_ff;
      CAP_DR: nxt_dr = dr_cap;
      SH_DR: begin
        for (int i = 0; i < DW; i++) begin
          if (i == dr_len - 1) begin
            nxt_dr[i] = TDI;
          end else if (i < dr_len - 1) begin
            nxt_dr[i] = dr_ff[i+1];
          end else begin
            nxt_dr[i] = 1'b0;
          end
        end
      end
      UPD_DR: begin
        if ((ir_ff == `BSTP_OP_EXTEST) || (ir_ff == `BSTP_OP_SAMPLE)) begin
          nxt_bsc = dr_ff[N_PINS-1:0];
          nxt_upd_tgl = ~upd_tgl_ff;
        end
        if (is_cfg && cfg_ok) begin
          nxt_hold = dr_ff[CFG_W-1:0];
          nxt_hold_nv = (ir_ff == `BSTP_OP_PROGRAM);
          nxt_cfg_tgl = ~cfg_tgl_ff;
        end
      end
      default: nxt_dr = dr_ff;
    endcase
    nxt_ext = (nxt_ir == `BSTP_OP_EXTEST);
    nxt_flt = (nxt_ir == `BSTP_OP_FLOAT);
    nxt_tdo_oe = (nxt_tap == SH_DR) || (nxt_tap == SH_IR);
    nxt_tdo = (nxt_tap == SH_IR) ? nxt_irsh[0]
      : (nxt_tap == SH_DR) ? nxt_dr[0] : 1'b0;
  end

  always_ff @(posedge TCK) begin
    rst_t1 <= RSTN;
    rst_t2 <= rst_t1;
    pin_t1 <= PIN_IN;
    pin_t2 <= pin_t1;
    rb_t1 <= RB_DATA;
    rb_t2 <= rb_t1;
    lck_t1 <= locked_ff;
    lck_t2 <= lck_t1;
    vpp_t1 <= VPP_OK;
    vpp_t2 <= vpp_t1;
    ack_t1 <= ack_ff;
    ack_t2 <= ack_t1;
    if (!rst_t2) begin
      tap_ff <= TLR;
      ir_ff <= `BSTP_IR_RST;
      irsh_ff <= '0;
      dr_ff <= '0;
      bsc_ff <= '0;
      upd_tgl_ff <= 1'b0;
      cfg_tgl_ff <= 1'b0;
      hold_ff <= '0;
      hold_nv_ff <= 1'b0;
      ext_ff <= 1'b0;
      flt_ff <= 1'b0;
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      tap_ff <= nxt_tap;
      ir_ff <= nxt_ir;
      irsh_ff <= nxt_irsh;
      dr_ff <= nxt_dr;
      bsc_ff <= nxt_bsc;
      upd_tgl_ff <= nxt_upd_tgl;
      cfg_tgl_ff <= nxt_cfg_tgl;
      hold_ff <= nxt_hold;
      hold_nv_ff <= nxt_hold_nv;
      ext_ff <= nxt_ext;
      flt_ff <= nxt_flt;
      tdo_ff <= nxt_tdo;
      tdo_oe_ff <= nxt_tdo_oe;
    end
  end

  assign TDO = tdo_ff;
  assign TDO_OE = tdo_oe_ff;

  a_bypass_delay: assert property (@(posedge TCK) disable iff (!rst_t2)
    (tap_ff == SH_DR && ir_ff == `BSTP_OP_BYPASS) ##1 (tap_ff == SH_DR)
    |-> TDO == $past(TDI)) else $error("bypass delay wrong");
  a_ir_update: assert property (@(posedge TCK) disable iff (!rst_t2)
    (tap_ff == UPD_IR) |=> (ir_ff == $past(irsh_ff)))
    else $error("instruction not loaded");
  a_id_capture: assert property (@(posedge TCK) disable iff (!rst_t2)
    (tap_ff == CAP_DR && ir_ff == `BSTP_OP_IDCODE)
    |=> dr_ff[31:0] == `BSTP_ID_CODE) else $error("bad id capture");
  a_sig_capture: assert property (@(posedge TCK) disable iff (!rst_t2)
    (tap_ff == CAP_DR && ir_ff == `BSTP_OP_USER_SIG)
    |=> dr_ff[31:0] == USIG_VALUE) else $error("bad signature");
  a_lock_blocks: assert property (@(posedge TCK) disable iff (!rst_t2)
    (tap_ff == CAP_DR && ir_ff == `BSTP_OP_READBACK && lck_t2)
    |=> dr_ff[CFG_W-1:0] == '0) else $error("readout leaked");
  a_pin_sample: assert property (@(posedge TCK) disable iff (!rst_t2)
    (tap_ff == CAP_DR && ir_ff == `BSTP_OP_SAMPLE)
    |=> dr_ff[N_PINS-1:0] == $past(pin_t2)) else $error("bad sample");
  a_unknown_pass: assert property (@(posedge TCK) disable iff (!rst_t2)
    (ir_ff == 5'h1e) |-> dr_len == 1)
    else $error("unknown opcode chain");
  a_tms_reset: assert property (@(posedge TCK) disable iff (!rst_t2)
    TMS [*5] |=> tap_ff == TLR) else $error("no tms reset");

  // ==========================================================
  // System clock side
  logic [N_PINS-1:0] pin_s1, pin_s2, bsc_sys_ff, nxt_bsc_sys;
  logic [N_PINS-1:0] pin_out_ff, nxt_pin_out, pin_oe_ff, nxt_pin_oe;
  logic [N_PINS-1:0] core_in_ff;
  logic ext_s1, ext_s2, flt_s1, flt_s2, upd_s1, upd_s2, upd_s3;
  logic cfg_s1, cfg_s2, sec_s1, sec_s2;
  logic [1:0] sec_wait_ff, nxt_sec_wait;
  logic [CFG_W-1:0] out_d_ff, nxt_out_d, f_out_d;
  logic out_v_ff, nxt_out_v, out_nv_ff, nxt_out_nv, f_out_nv;
  logic f_in_ready, f_out_valid, f_out_ready, pend;

  always_comb begin
    nxt_bsc_sys = (upd_s2 != upd_s3) ? bsc_ff : bsc_sys_ff;
    nxt_pin_out = ext_s2 ? bsc_sys_ff : CORE_OUT;
    nxt_pin_oe = ext_s2 ? {N_PINS{1'b1}} : CORE_OE;
    if (flt_s2) begin
      nxt_pin_oe = '0;
    end
    nxt_sec_wait = sec_wait_ff;
    nxt_locked = locked_ff;
    if (sec_wait_ff != `BSTP_SEC_WAIT) begin
      nxt_sec_wait = sec_wait_ff + 2'h1;
      nxt_locked = sec_s2;
    end
    // Ack only after the push, so a full FIFO stalls the controller
    pend = (cfg_s2 != ack_ff);
    nxt_ack = (pend && f_in_ready) ? cfg_s2 : ack_ff;
    f_out_ready = !out_v_ff || CFG_READY;
    nxt_out_v = out_v_ff;
    nxt_out_d = out_d_ff;
    nxt_out_nv = out_nv_ff;
    if (f_out_ready) begin
      nxt_out_v = f_out_valid;
      nxt_out_d = f_out_d;
      nxt_out_nv = f_out_nv;
    end
  end

  // words from the test port only
  bstp_fifo #(.W(CFG_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .in_data({hold_nv_ff, hold_ff}),
    .in_valid(pend),
    .in_ready(f_in_ready),
    .out_data({f_out_nv, f_out_d}),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready)
  );

  always_ff @(posedge CLK_SYS) begin
    pin_s1 <= PIN_IN;
    pin_s2 <= pin_s1;
    ext_s1 <= ext_ff;
    ext_s2 <= ext_s1;
    flt_s1 <= flt_ff;
    flt_s2 <= flt_s1;
    upd_s1 <= upd_tgl_ff;
    upd_s2 <= upd_s1;
    cfg_s1 <= cfg_tgl_ff;
    cfg_s2 <= cfg_s1;
    sec_s1 <= SEC_BIT_NV;
    sec_s2 <= sec_s1;
    if (!RSTN) begin
      upd_s3 <= 1'b0;
      bsc_sys_ff <= '0;
      pin_out_ff <= '0;
      pin_oe_ff <= '0;
      core_in_ff <= '0;
      ack_ff <= 1'b0;
      locked_ff <= 1'b1;
      sec_wait_ff <= 2'h0;
      out_v_ff <= 1'b0;
      out_d_ff <= '0;
      out_nv_ff <= 1'b0;
    end else begin
      upd_s3 <= upd_s2;
      bsc_sys_ff <= nxt_bsc_sys;
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
      core_in_ff <= pin_s2;
      ack_ff <= nxt_ack;
      locked_ff <= nxt_locked;
      sec_wait_ff <= nxt_sec_wait;
      out_v_ff <= nxt_out_v;
      out_d_ff <= nxt_out_d;
      out_nv_ff <= nxt_out_nv;
    end
  end

  assign PIN_OUT = pin_out_ff;
  assign PIN_OE = pin_oe_ff;
  assign CORE_IN = core_in_ff;
  assign CFG_DATA = out_d_ff;
  assign CFG_NV = out_nv_ff;
  assign CFG_VALID = out_v_ff;
  assign SEC_LOCKED = locked_ff;

  a_float_pins: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    flt_s2 |=> PIN_OE == '0) else $error("pins not floated");
  a_extest_drive: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (ext_s2 && !flt_s2) |=> (PIN_OUT == $past(bsc_sys_ff))
    && (PIN_OE == '1)) else $error("extest not driving");
  a_sec_frozen: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (sec_wait_ff == `BSTP_SEC_WAIT) |=> $stable(locked_ff))
    else $error("security changed");
  a_cfg_hold: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (CFG_VALID && !CFG_READY) |=> CFG_VALID && $stable(CFG_DATA))
    else $error("word lost");
endmodule

// ### testbench/bstp_ctl_model.sv
// External test controller model driving the four-wire test port
`timescale 1ns/10ps
module bstp_ctl_model (
  output logic TCK,
  output logic TMS,
  output logic TDI,
  input wire logic TDO,
  input wire logic TDO_OE
);
  int oe_miss;

  initial begin
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b1;
    oe_miss = 0;
  end

  // ==========================================================
  // One test clock period
  // inputs driven here, clock idle between frames
  // same four wires for every transfer
  // TDI flipped after the rise: a stale level must not pass
  task automatic step(input logic m, input logic d);
    #1 TMS = m;
    TDI = d;
    #6 TCK = 1'b1;
    #1 TDI = ~d;
    #7 TCK = 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) step(1'b1, 1'b1);
  endtask

  // ==========================================================
  // Shift walk, starts and ends in Run-Test/Idle
  // standard state sequence, LSB first
  task automatic shift(input logic ir, input int n, input logic [31:0] din,
      output logic [31:0] dout);
    dout = '0;
    step(1'b1, 1'b0);
    if (ir) begin
      step(1'b1, 1'b0);
    end
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      dout[i] = TDO;
      if (TDO_OE !== 1'b1) begin
        oe_miss++;
      end
      step(i == n - 1, din[i]);
    end
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
endmodule

// ### testbench/bstp_top_tb.sv
// Self-checking bench for the boundary scan test port
`timescale 1ns/10ps
`include "bstp_consts.svh"
module bstp_top_tb;
  localparam logic [31:0] USIG_V = 32'h5a3c_c3a5;
  logic clk_sys, rst_n, tck, tms, tdi, tdo, tdo_oe;
  logic [7:0] pin_in, core_out, core_oe, pin_out, pin_oe, core_in;
  logic sec_bit_nv, vpp_ok, cfg_nv, cfg_valid, cfg_ready, sec_locked;
  logic [7:0] rb_data, cfg_data;
  logic [31:0] rd;
  int fail_count;
  int checked;

  bstp_ctl_model ctl_u (.TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo),
    .TDO_OE(tdo_oe));

  bstp_top #(.USIG_VALUE(USIG_V)) dut_u (.CLK_SYS(clk_sys), .RSTN(rst_n),
    .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe),
    .PIN_IN(pin_in), .CORE_OUT(core_out), .CORE_OE(core_oe),
    .PIN_OUT(pin_out), .PIN_OE(pin_oe), .CORE_IN(core_in),
    .SEC_BIT_NV(sec_bit_nv), .VPP_OK(vpp_ok), .RB_DATA(rb_data),
    .CFG_DATA(cfg_data), .CFG_NV(cfg_nv), .CFG_VALID(cfg_valid),
    .CFG_READY(cfg_ready), .SEC_LOCKED(sec_locked));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // Helpers
  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic sys(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic ir(input logic [4:0] op);
    ctl_u.shift(1'b1, 5, {27'h0, op}, rd);
    chk(rd, 32'h1);
  endtask

  task automatic dr(input int n, input logic [31:0] din);
    ctl_u.shift(1'b0, n, din, rd);
  endtask

  // Word handshake is slow on purpose: one edge idle between takes
  task automatic take;
    cfg_ready = 1'b1;
    sys(1);
    cfg_ready = 1'b0;
    sys(1);
  endtask

  task automatic wait_valid;
    int k;
    k = 0;
    while (cfg_valid !== 1'b1 && k < 50) begin
      sys(1);
      k++;
    end
    if (k == 50) begin
      fail_count++;
      wrap_up;
    end
  endtask

  task automatic do_reset(input logic sec);
    sec_bit_nv = sec;
    sys(1);
    rst_n = 1'b0;
    ctl_u.idle(4);
    sys(3);
    rst_n = 1'b1;
    ctl_u.idle(3);
    ctl_u.step(1'b0, 1'b0);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_id;
    dr(32, 32'h0);
    chk(rd, `BSTP_ID_CODE);
    chk(32'(ctl_u.oe_miss), 32'h0);
    ir(`BSTP_OP_USER_SIG);
    dr(32, 32'h0);
    chk(rd, USIG_V);
    ir(`BSTP_OP_IDCODE);
    dr(32, 32'hffff_ffff);
    chk(rd, `BSTP_ID_CODE);
  endtask

  task automatic t_bypass;
    logic [4:0] ops [6] = '{5'h1f, 5'h18, 5'h1e, 5'h05, 5'h0c, 5'h14};
    foreach (ops[i]) begin
      ir(ops[i]);
      dr(3, 32'h3);
      chk(rd, 32'h6);
    end
  endtask

  task automatic t_pins;
    sys(1);
    pin_in = 8'ha5;
    core_out = 8'h5a;
    core_oe = 8'h0f;
    ir(`BSTP_OP_SAMPLE);
    sys(4);
    dr(8, 32'h3c);
    chk(rd, 32'ha5);
    chk({8'h0, core_in, pin_out, pin_oe}, 32'ha55a0f);
    ir(`BSTP_OP_EXTEST);
    sys(8);
    chk({16'h0, pin_out, pin_oe}, 32'h3cff);
    dr(8, 32'hc3);
    sys(8);
    chk({16'h0, pin_out, pin_oe}, 32'hc3ff);
  endtask

  task automatic t_float;
    ir(`BSTP_OP_FLOAT);
    sys(8);
    chk(32'(pin_oe), 32'h0);
    ir(`BSTP_OP_BYPASS);
    sys(8);
    chk({16'h0, pin_out, pin_oe}, 32'h5a0f);
  endtask

  // Consumer stalls: output stage plus 32 buffered, one waits, one is lost
  // Gap lets the acknowledge cross back before the next capture
  task automatic t_cfg;
    ir(`BSTP_OP_RECONFIG);
    for (int i = 0; i < 35; i++) begin
      dr(8, 32'h40 + i);
      chk(32'(rd[0]), 32'(i < 34));
      sys(4);
    end
    for (int i = 0; i < 34; i++) begin
      wait_valid;
      chk(32'({cfg_nv, cfg_data}), 32'h40 + i);
      take;
    end
    sys(8);
    chk(32'(cfg_valid), 32'h0);
  endtask

  task automatic t_prog;
    ir(`BSTP_OP_PROGRAM);
    dr(8, 32'h77);
    sys(12);
    chk(32'(cfg_valid), 32'h0);
    vpp_ok = 1'b1;
    dr(8, 32'h99);
    wait_valid;
    chk(32'({cfg_nv, cfg_data}), 32'h199);
    take;
  endtask

  task automatic t_sec;
    do_reset(1'b1);
    chk(32'(sec_locked), 32'h1);
    ir(`BSTP_OP_READBACK);
    dr(8, 32'h0);
    chk(rd, 32'h0);
    sec_bit_nv = 1'b0;
    ir(`BSTP_OP_RECONFIG);
    dr(8, 32'h21);
    wait_valid;
    take;
    chk(32'(sec_locked), 32'h1);
    ir(`BSTP_OP_READBACK);
    dr(8, 32'h0);
    chk(rd, 32'h0);
    do_reset(1'b0);
    chk(32'(sec_locked), 32'h0);
    ir(`BSTP_OP_READBACK);
    dr(8, 32'h0);
    chk(rd, 32'hb6);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    fail_count = 0;
    checked = 0;
    rst_n = 1'b0;
    pin_in = 8'h00;
    core_out = 8'h00;
    core_oe = 8'h00;
    sec_bit_nv = 1'b0;
    vpp_ok = 1'b0;
    rb_data = 8'hb6;
    cfg_ready = 1'b0;
    do_reset(1'b0);
    t_id;
    t_bypass;
    t_pins;
    t_float;
    t_cfg;
    t_prog;
    t_sec;
    wrap_up;
  end
endmodule
